// ==== sim/chan3_cal_and_filter_status_regs_tb_top.sv ====
/*
 * Self-checking bench for the channel 3 trim and filter status bank.
 * Assumes the design and checker files are compiled before it.
 */
`timescale 1ns/1ps
`include "cal_regs_consts.svh"
`define CHECK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module chan3_cal_and_filter_status_regs_tb_top;
    localparam int DIV = 10;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [7:0] gain_low = 8'h00;
    cal_regs_pkg::sample_s s_in = '0;
    cal_regs_pkg::sample_s s_out;
    logic [3:0] fault = 4'h0;
    logic [3:0] steady = 4'h0;
    logic [31:0] rd;
    int num_errors = 0;
    int checks_done = 0;

    chan3_cal_and_filter_status_regs #(.TALLY_DIV(DIV)) i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .chan3_gain_trim_low(gain_low), .chan3_in(s_in), .chan3_out(s_out),
        .filter_range_fault(fault), .filter_steady(steady)
    );

    initial forever #5 ref_clk = ~ref_clk;

    // ----
    // Bus tasks
    // ----
    task bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task wr(input logic [7:0] idx, input logic [31:0] wd);
        bus(idx, 1'b1, wd);
    endtask : wr

    task rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 32'h0);
        `CHECK(nm, exp, rd)
    endtask : rdchk

    task sample(input string nm, input logic [23:0] din, input logic [23:0] exp);
        @(posedge ref_clk);
        s_in <= {1'b1, din};
        @(posedge ref_clk);
        s_in <= '0;
        @(posedge ref_clk);
        #1;
        `CHECK(nm, {1'b1, exp}, s_out)
    endtask : sample

    // ----
    // Scenarios
    // ----
    task test_reset;
        for (int i = 8'h3a; i <= 8'h41; i++) rdchk("reset_reg", i[7:0], 32'h0);
        rdchk("reset_irq", `REG_IRQ_STATUS, 32'h0);
    endtask : test_reset

    task test_trims;
        wr(`REG_GAIN_MID, 32'hffff_ffa5);
        wr(`REG_GAIN_TOP, 32'hff);
        wr(`REG_OFFS_LOW, 32'h5a);
        wr(`REG_OFFS_MID, 32'hc3);
        wr(`REG_OFFS_TOP, 32'hff);
        wr(`REG_TALLY, 32'hff);
        wr(`REG_FAULT, 32'hff);
        wr(`REG_STEADY, 32'hff);
        wr(8'h80, 32'hff);
        rdchk("gain_mid", `REG_GAIN_MID, 32'ha5);
        rdchk("gain_top", `REG_GAIN_TOP, 32'h1f);
        rdchk("offs_low", `REG_OFFS_LOW, 32'h5a);
        rdchk("offs_mid", `REG_OFFS_MID, 32'hc3);
        rdchk("offs_top", `REG_OFFS_TOP, 32'hff);
        rdchk("tally_ro", `REG_TALLY, 32'h0);
        rdchk("fault_ro", `REG_FAULT, 32'h0);
        rdchk("steady_ro", `REG_STEADY, 32'h0);
        rdchk("unmapped", 8'h80, 32'h0);
    endtask : test_trims

    task test_tally;
        wr(`REG_CTRL, 32'h1);
        repeat (256 * DIV + 100) @(posedge ref_clk);
        rdchk("tally_full", `REG_TALLY, 32'hff);
        repeat (3 * DIV) @(posedge ref_clk);
        rdchk("tally_held", `REG_TALLY, 32'hff);
        rdchk("tally_irq", `REG_IRQ_STATUS, 32'h1);
        wr(`REG_CTRL, 32'h0);
        wr(`REG_CTRL, 32'h1);
        repeat (100) @(posedge ref_clk);
        bus(`REG_TALLY, 1'b0, 32'h0);
        `CHECK("tally_rate", 1'b1, rd >= 32'd9 && rd <= 32'd11)
        wr(`REG_CTRL, 32'h0);
    endtask : test_tally

    task test_irq;
        logic [3:0] b;
        wr(`REG_IRQ_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        `CHECK("irq_on", 1'b1, irq)
        wr(`REG_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge ref_clk);
        `CHECK("irq_off", 1'b0, irq)
        wr(`REG_IRQ_MASK, 32'h2);
        for (int n = 0; n < 4; n++) begin
            b = 4'h1 << n;
            @(posedge ref_clk);
            fault <= b;
            steady <= ~b;
            repeat (2) @(posedge ref_clk);
            rdchk("fault_bit", `REG_FAULT, {28'h0, b});
            rdchk("steady_bit", `REG_STEADY, {28'h0, ~b});
        end
        `CHECK("irq_fault", 1'b1, irq)
        rdchk("irq_status", `REG_IRQ_STATUS, 32'h6);
        wr(`REG_IRQ_STATUS, 32'h6);
        repeat (2) @(posedge ref_clk);
        `CHECK("irq_cleared", 1'b0, irq)
        wr(`REG_IRQ_MASK, 32'h0);
        fault <= 4'h0;
        repeat (2) @(posedge ref_clk);
        fault <= 4'hf;
        repeat (3) @(posedge ref_clk);
        `CHECK("irq_masked", 1'b0, irq)
        rdchk("masked_status", `REG_IRQ_STATUS, 32'h2);
    endtask : test_irq

    task test_samples;
        wr(`REG_GAIN_TOP, 32'h0);
        wr(`REG_OFFS_TOP, 32'h0);
        sample("plain", 24'h123456, 24'h123456);
        wr(`REG_OFFS_LOW, 32'h03);
        wr(`REG_OFFS_MID, 32'h02);
        wr(`REG_OFFS_TOP, 32'h81);
        sample("offset", 24'h000100, 24'h010303);
        wr(`REG_OFFS_TOP, 32'h01);
        sample("offset_off", 24'h000100, 24'h000100);
        wr(`REG_GAIN_MID, 32'h0);
        wr(`REG_GAIN_TOP, 32'h14);
        sample("gain_half", 24'h000100, 24'h000080);
        gain_low <= 8'h80;
        wr(`REG_GAIN_MID, 32'h01);
        sample("gain_full", 24'h080000, 24'h040180);
        wr(`REG_GAIN_TOP, 32'h04);
        sample("gain_off", 24'h000100, 24'h000100);
    endtask : test_samples

    // ----
    // Verdict
    // ----
    task summarize;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        test_reset();
        test_trims();
        test_tally();
        test_irq();
        test_samples();
        summarize();
    end
endmodule : chan3_cal_and_filter_status_regs_tb_top

// ==== sim/chan3_regs_checker.sv ====
/*
 * Port assertions for the channel 3 trim and filter status register bank.
 * Assumes it is bound to the bank's top module, one clock domain.
 */
`timescale 1ns/1ps
`include "cal_regs_consts.svh"

module chan3_regs_checker #(
    parameter int TALLY_DIV = 12000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Interrupt and samples
    input wire logic irq,
    input wire logic [7:0] chan3_gain_trim_low,
    input cal_regs_pkg::sample_s chan3_in,
    input cal_regs_pkg::sample_s chan3_out,
    // Filter status
    input wire logic [3:0] filter_range_fault,
    input wire logic [3:0] filter_steady
);
    logic take_rd;
    logic take_wr;

    assign take_rd = hsel && htrans[1] && hready && !hwrite;
    assign take_wr = hsel && htrans[1] && hready && hwrite;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    chk_read_wait: assert property (take_rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (take_wr |=> hreadyout)
        else $error("write stalled");
    chk_data_hold: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("read data changed outside a read");
    chk_upper_zero: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_gain_rsvd: assert property (take_rd && haddr == {22'h0, `REG_GAIN_TOP, 2'b00}
        |-> ##2 hrdata[7:5] == 3'h0)
        else $error("gain top reserved bits set");
    chk_fault_live: assert property (take_rd && haddr == {22'h0, `REG_FAULT, 2'b00}
        |-> ##2 hrdata[7:0] == {4'h0, $past(filter_range_fault, 2)})
        else $error("fault flags wrong");
    chk_steady_live: assert property (take_rd && haddr == {22'h0, `REG_STEADY, 2'b00}
        |-> ##2 hrdata[7:0] == {4'h0, $past(filter_steady, 2)})
        else $error("steady flags wrong");
    chk_sample_lat: assert property (chan3_in.valid |-> ##2 chan3_out.valid)
        else $error("sample latency wrong");
endmodule : chan3_regs_checker

bind chan3_cal_and_filter_status_regs chan3_regs_checker #(.TALLY_DIV(TALLY_DIV)) i_chk (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .chan3_gain_trim_low(chan3_gain_trim_low), .chan3_in(chan3_in), .chan3_out(chan3_out),
    .filter_range_fault(filter_range_fault), .filter_steady(filter_steady)
);

// ==== verilog/cal_regs_consts.svh ====
/*
 * Offsets, field positions, reset values and timing counts of the channel 3
 * trim and filter status register bank.
 * Assumes inclusion by bare name from any design file that needs them.
 */
`ifndef CAL_REGS_CONSTS_SVH
`define CAL_REGS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define REG_GAIN_MID 8'h3a
`define REG_GAIN_TOP 8'h3b
`define REG_OFFS_LOW 8'h3c
`define REG_OFFS_MID 8'h3d
`define REG_OFFS_TOP 8'h3e
`define REG_TALLY 8'h3f
`define REG_FAULT 8'h40
`define REG_STEADY 8'h41
`define REG_CTRL 8'h50
`define REG_IRQ_STATUS 8'h51
`define REG_IRQ_MASK 8'h52

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GAIN_ON_BIT 4
`define OFFS_ON_BIT 7
`define TALLY_START_BIT 0
`define IRQ_TALLY_DONE_BIT 0
`define IRQ_FAULT_BIT 1
`define IRQ_STEADY_BIT 2

// ----------------------------------------------------------------------
// Reset values and arithmetic
// ----------------------------------------------------------------------
`define RESET_BYTE 8'h00
`define RESET_IRQ 3'h0
`define GAIN_UNITY_SHIFT 19

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define TALLY_DIV 12000
`define TALLY_MAX 8'hff

`endif

// ==== verilog/cal_regs_pkg.sv ====
/*
 * Types shared by the channel 3 trim and filter status register bank.
 * Assumes nothing of its surroundings.
 */
package cal_regs_pkg;

    // ------------------------------------------------------------------
    // Bus and tally states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_READ = 1'b1
    } bus_state_e;

    typedef enum logic [1:0] {
        TALLY_IDLE = 2'b00,
        TALLY_RUN = 2'b01,
        TALLY_DONE = 2'b10
    } tally_state_e;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic hit;
        logic [7:0] idx;
    } data_phase_s;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } sample_s;

endpackage : cal_regs_pkg

// ==== verilog/chan3_cal_and_filter_status_regs.sv ====
/*
 * Channel 3 gain and offset trim, master clock tally and filter status
 * registers behind an AHB-Lite slave, with the channel 3 correction path.
 * Assumes a single AHB-Lite master whose hready is this slave's hreadyout,
 * word transfers only, and filter status inputs on the ref_clk domain.
 */
// Chosen here: the AHB-Lite slave port.
// Operation
// - Channel 3 gain trim is 20 bits, bits 15:8 in one register and 19:16 in the next low nibble.
// - Bit 4 of the upper gain register is read/write and turns on channel 3 gain correction.
// - Channel 3 offset trim is 23 bits over three registers, top seven bits in the upper one.
// - Bit 7 of the upper offset register is read/write and turns on channel 3 offset correction.
// - The tally is an 8-bit read-only count advancing once every 12000 master clock cycles.
// - Counting starts when software sets the start bit and stops when the count reaches 255.
// - Bit n of the fault register shows an overflow or underflow in channel n's filter.
// - Bit n of the steady register shows that channel n's filter has settled.
// - Every register of the bank resets to zero.
`timescale 1ns/1ps
`include "cal_regs_consts.svh"

module chan3_cal_and_filter_status_regs #(
    parameter int TALLY_DIV = `TALLY_DIV
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt
    output logic irq,
    // Channel 3 sample path
    input wire logic [7:0] chan3_gain_trim_low,
    input cal_regs_pkg::sample_s chan3_in,
    output cal_regs_pkg::sample_s chan3_out,
    // Filter status
    input wire logic [3:0] filter_range_fault,
    input wire logic [3:0] filter_steady
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [23:0] sat24(input logic signed [47:0] v);
        logic [23:0] r;
        if (v > 48'sh0000007fffff) begin
            r = 24'h7fffff;
        end else if (v < -48'sh000000800000) begin
            r = 24'h800000;
        end else begin
            r = v[23:0];
        end
        return r;
    endfunction : sat24

    function automatic logic word_hit(input logic [31:0] a);
        return (a[31:10] == 22'h000000) && (a[1:0] == 2'h0);
    endfunction : word_hit

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] gain_mid;
    logic [3:0] gain_top;
    logic gain_on;
    logic [7:0] offs_low;
    logic [7:0] offs_mid;
    logic [6:0] offs_top;
    logic offs_on;
    logic tally_start;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [3:0] fault_flags;
    logic [3:0] steady_flags;
    logic [7:0] tally_count;
    logic tally_done;
    logic [19:0] chan3_gain_trim;
    logic [22:0] chan3_offset_trim;

    assign chan3_gain_trim = {gain_top, gain_mid, chan3_gain_trim_low};
    assign chan3_offset_trim = {offs_top, offs_mid, offs_low};

    // ------------------------------------------------------------------
    // Bus address and data phase
    // ------------------------------------------------------------------
    cal_regs_pkg::bus_state_e bus_state;
    cal_regs_pkg::data_phase_s dphase;
    logic take;
    logic wr_en;

    assign take = hsel && htrans[1] && hready;
    assign wr_en = dphase.valid && dphase.write && dphase.hit;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dphase <= '0;
        end else if (hready) begin
            if (take) begin
                dphase.valid <= 1'b1;
                dphase.write <= hwrite;
                dphase.hit <= word_hit(haddr);
                dphase.idx <= haddr[9:2];
            end else begin
                dphase <= '0;
            end
        end
    end

    // One wait state on reads lets a preceding write land first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state <= cal_regs_pkg::BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
        end else begin
            case (bus_state)
                cal_regs_pkg::BUS_IDLE: begin
                    if (take && !hwrite) begin
                        bus_state <= cal_regs_pkg::BUS_READ;
                        hreadyout <= 1'b0;
                    end
                end
                cal_regs_pkg::BUS_READ: begin
                    hrdata <= dphase.hit ? read_word(dphase.idx) : 32'h00000000;
                    hreadyout <= 1'b1;
                    bus_state <= cal_regs_pkg::BUS_IDLE;
                end
                default: begin
                    bus_state <= cal_regs_pkg::BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    function automatic logic [31:0] read_word(input logic [7:0] idx);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            `REG_GAIN_MID: begin
                b = gain_mid;
            end
            `REG_GAIN_TOP: begin
                b = {3'h0, gain_on, gain_top};
            end
            `REG_OFFS_LOW: begin
                b = offs_low;
            end
            `REG_OFFS_MID: begin
                b = offs_mid;
            end
            `REG_OFFS_TOP: begin
                b = {offs_on, offs_top};
            end
            `REG_TALLY: begin
                b = tally_count;
            end
            `REG_FAULT: begin
                b = {4'h0, fault_flags};
            end
            `REG_STEADY: begin
                b = {4'h0, steady_flags};
            end
            `REG_CTRL: begin
                b = {7'h00, tally_start};
            end
            `REG_IRQ_STATUS: begin
                b = {5'h00, irq_status};
            end
            `REG_IRQ_MASK: begin
                b = {5'h00, irq_mask};
            end
            default: begin
                b = 8'h00;
            end
        endcase
        return {24'h000000, b};
    endfunction : read_word

    // ------------------------------------------------------------------
    // Trim registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_mid <= `RESET_BYTE;
            gain_top <= 4'h0;
            gain_on <= 1'b0;
        end else if (wr_en) begin
            if (dphase.idx == `REG_GAIN_MID) begin
                gain_mid <= hwdata[7:0];
            end
            if (dphase.idx == `REG_GAIN_TOP) begin
                gain_top <= hwdata[3:0];
                gain_on <= hwdata[`GAIN_ON_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            offs_low <= `RESET_BYTE;
            offs_mid <= `RESET_BYTE;
            offs_top <= 7'h00;
            offs_on <= 1'b0;
        end else if (wr_en) begin
            if (dphase.idx == `REG_OFFS_LOW) begin
                offs_low <= hwdata[7:0];
            end
            if (dphase.idx == `REG_OFFS_MID) begin
                offs_mid <= hwdata[7:0];
            end
            if (dphase.idx == `REG_OFFS_TOP) begin
                offs_top <= hwdata[6:0];
                offs_on <= hwdata[`OFFS_ON_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Tally control
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tally_start <= 1'b0;
        end else if (wr_en && (dphase.idx == `REG_CTRL)) begin
            tally_start <= hwdata[`TALLY_START_BIT];
        end
    end

    tally_counter #(
        .DIV(TALLY_DIV)
    ) u_tally (
        .clk(ref_clk),
        .rst_n(rst_n),
        .start(tally_start),
        .count(tally_count),
        .done(tally_done)
    );

    // ------------------------------------------------------------------
    // Filter status
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_flags <= 4'h0;
            steady_flags <= 4'h0;
        end else begin
            fault_flags <= filter_range_fault;
            steady_flags <= filter_steady;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic [2:0] next_irq_status;

    always_comb begin
        irq_set = 3'h0;
        irq_set[`IRQ_TALLY_DONE_BIT] = tally_done;
        irq_set[`IRQ_FAULT_BIT] = |(filter_range_fault & ~fault_flags);
        irq_set[`IRQ_STEADY_BIT] = |(filter_steady & ~steady_flags);
        irq_clr = 3'h0;
        if (wr_en && (dphase.idx == `REG_IRQ_STATUS)) begin
            irq_clr = hwdata[2:0];
        end
        // A new event outranks a clear in the same cycle
        next_irq_status = (irq_status & ~irq_clr) | irq_set;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= `RESET_IRQ;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= `RESET_IRQ;
        end else if (wr_en && (dphase.idx == `REG_IRQ_MASK)) begin
            irq_mask <= hwdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Channel 3 correction, offset then gain
    // ------------------------------------------------------------------
    cal_regs_pkg::sample_s stage1;
    logic [23:0] next_offs_data;
    logic [23:0] next_gain_data;
    logic signed [47:0] offs_sum;
    logic signed [47:0] gain_prod;

    always_comb begin
        offs_sum = $signed({{24{chan3_in.data[23]}}, chan3_in.data})
            + $signed({{25{chan3_offset_trim[22]}}, chan3_offset_trim});
        if (offs_on) begin
            next_offs_data = sat24(offs_sum);
        end else begin
            next_offs_data = chan3_in.data;
        end
    end

    always_comb begin
        gain_prod = $signed({{24{stage1.data[23]}}, stage1.data})
            * $signed({28'h0000000, chan3_gain_trim});
        if (gain_on) begin
            next_gain_data = sat24(gain_prod >>> `GAIN_UNITY_SHIFT);
        end else begin
            next_gain_data = stage1.data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
        end else begin
            stage1.valid <= chan3_in.valid;
            stage1.data <= next_offs_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan3_out <= '0;
        end else begin
            chan3_out.valid <= stage1.valid;
            chan3_out.data <= next_gain_data;
        end
    end

endmodule : chan3_cal_and_filter_status_regs

// ==== verilog/tally_counter.sv ====
/*
 * Master clock tally: a prescaler of DIV cycles advancing an 8-bit count.
 * Assumes a synchronous active-low reset copy and a start level on the same clock.
 */
`timescale 1ns/1ps
`include "cal_regs_consts.svh"

module tally_counter #(
    parameter int DIV = `TALLY_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    // Result
    output logic [7:0] count,
    output logic done
);

    localparam int PW = $clog2(DIV + 1);

    cal_regs_pkg::tally_state_e state;
    logic [PW-1:0] pre;
    logic start_d;

    // ------------------------------------------------------------------
    // Start edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_d <= 1'b0;
        end else begin
            start_d <= start;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and count
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= cal_regs_pkg::TALLY_IDLE;
            pre <= '0;
            count <= `RESET_BYTE;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !start_d) begin
                // Fresh measurement on each setting of the start bit
                state <= cal_regs_pkg::TALLY_RUN;
                pre <= '0;
                count <= `RESET_BYTE;
            end else begin
                case (state)
                    cal_regs_pkg::TALLY_IDLE: begin
                        pre <= '0;
                    end
                    cal_regs_pkg::TALLY_RUN: begin
                        if (!start) begin
                            state <= cal_regs_pkg::TALLY_IDLE;
                        end else if (pre == PW'(DIV - 1)) begin
                            pre <= '0;
                            count <= count + 8'h01;
                            if (count == `TALLY_MAX - 8'h01) begin
                                state <= cal_regs_pkg::TALLY_DONE;
                                done <= 1'b1;
                            end
                        end else begin
                            pre <= pre + PW'(1);
                        end
                    end
                    cal_regs_pkg::TALLY_DONE: begin
                        pre <= '0;
                    end
                    default: begin
                        state <= cal_regs_pkg::TALLY_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : tally_counter
